// ==== design/cpif_core_end.sv ====
// Core end of the coprocessor interface
// Functional notes
// - Coprocessor pipeline runs one cycle behind core
// - Flag valid instruction in issue and decode
// - Report previous-cycle decode and execute stalls
// - Report previous-cycle load/store unit holds
// - Single cancel kills last execute instruction
// - Flush kills last execute and younger
// - Flush overrides stall and valid; busy drops
// - Bounce takes undefined instruction exception
// - Busy input stalls core execute stage
// - Spare decode busy inputs tied low
// - Two separate 64-bit data buses
// - Owner drives load/store length, swap, doubleword
// - Spare abort output driven low
// - Interface signals driven straight from registers
// - Broadcast outputs; replies combined by AND/OR
// - Two input sets; unused set tied off
// - Non-owner drives AND high, OR low
// - Extra coprocessors need external data combining
// - Extra coprocessors' holds ORed externally
// - Unique ID 0..15 must match instruction
// - Accept by driving bounce low
// - Matching coprocessor may still decline
`include "cpif_consts.svh"
module cpif_core_end (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link
    cpif_if.core cp,
    // Pipeline side: instruction entering issue
    input wire logic pipe_issue_valid,
    input wire logic [`CPIF_INSTR_W-1:0] pipe_issue_instr,
    // Pipeline side: stall and kill causes
    input wire logic pipe_decode_stall,
    input wire logic pipe_lsu_exec_hold,
    input wire logic pipe_lsu_mem_hold,
    input wire logic pipe_cancel,
    input wire logic pipe_flush,
    // Pipeline side: store data towards coprocessors
    input wire logic [`CPIF_DATA_W-1:0] pipe_store_data,
    // Results seen in execute
    output logic exec_valid_q,
    output logic exec_stall_q,
    output logic undef_trap_q,
    output logic [`CPIF_LEN_W-1:0] ls_len_q,
    output logic ls_swap_q,
    output logic ls_dbl_q,
    output logic [`CPIF_DATA_W-1:0] load_data_q
);
    // ==========================================================
    // Combined coprocessor replies
    logic busy_in;
    logic bounce_in;
    logic exec_stall_d;
    logic dec_valid;
    logic [`CPIF_INSTR_W-1:0] dec_instr;
    logic ex_valid;
    logic [`CPIF_INSTR_W-1:0] ex_instr;
    logic ex2_valid;
    logic [`CPIF_INSTR_W-1:0] ex2_instr;
    logic iss_valid_q;
    logic [`CPIF_INSTR_W-1:0] iss_instr_q;

    assign busy_in = cp.execute_busy_wait1 | cp.execute_busy_wait2;
    assign bounce_in = cp.reject_to_undefined1 & cp.reject_to_undefined2;
    // Spare decode busy inputs are ignored; integrator ties them low
    assign exec_stall_d = ex2_valid & busy_in & !pipe_flush;

    // ==========================================================
    // Internal issue, decode and execute stages
    always_ff @(posedge core_clk) begin
        if (!rst_n || pipe_flush) begin
            iss_valid_q <= 1'b0;
            iss_instr_q <= '0;
        end else if (!(pipe_decode_stall || exec_stall_d)) begin
            iss_valid_q <= pipe_issue_valid;
            iss_instr_q <= pipe_issue_valid ? pipe_issue_instr : '0;
        end
    end

    cpif_stage #(.W(`CPIF_INSTR_W)) u_dec (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold(pipe_decode_stall | exec_stall_d),
        .kill(pipe_flush),
        .in_valid(iss_valid_q),
        .in_data(iss_instr_q),
        .out_valid(dec_valid),
        .out_data(dec_instr)
    );

    cpif_stage #(.W(`CPIF_INSTR_W)) u_ex (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold(exec_stall_d),
        .kill(pipe_flush | (pipe_decode_stall & !exec_stall_d)),
        .in_valid(dec_valid),
        .in_data(dec_instr),
        .out_valid(ex_valid),
        .out_data(ex_instr)
    );

    // Execute as the link shows it: outputs are registered, so one stage later
    cpif_stage #(.W(`CPIF_INSTR_W)) u_ex2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold(exec_stall_d),
        .kill(pipe_flush | pipe_cancel),
        .in_valid(ex_valid),
        .in_data(ex_instr),
        .out_valid(ex2_valid),
        .out_data(ex2_instr)
    );

    // ==========================================================
    // Registered outputs to coprocessors
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cp.issue_stage_valid <= 1'b0;
            cp.issue_instr <= '0;
            cp.decode_stage_valid <= 1'b0;
        end else begin
            cp.issue_stage_valid <= iss_valid_q & !pipe_flush;
            cp.issue_instr <= iss_instr_q;
            cp.decode_stage_valid <= dec_valid & !pipe_flush;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cp.core_decode_stalled <= 1'b0;
            cp.core_execute_stalled <= 1'b0;
        end else begin
            // Stall seen this cycle is reported next cycle
            cp.core_decode_stalled <= pipe_decode_stall & !pipe_flush;
            cp.core_execute_stalled <= exec_stall_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cp.lsu_execute_hold <= 1'b0;
            cp.lsu_memory_hold <= 1'b0;
        end else begin
            cp.lsu_execute_hold <= pipe_lsu_exec_hold;
            cp.lsu_memory_hold <= pipe_lsu_mem_hold;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cp.cancel_single <= 1'b0;
            cp.flush_from_execute <= 1'b0;
        end else begin
            cp.cancel_single <= pipe_cancel & !pipe_flush;
            cp.flush_from_execute <= pipe_flush;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cp.core_to_cp_data <= '0;
            cp.spare_abort_out <= 1'b0;
        end else begin
            cp.core_to_cp_data <= pipe_store_data;
            cp.spare_abort_out <= 1'b0;
        end
    end

    // ==========================================================
    // Execute-stage results
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            exec_valid_q <= 1'b0;
            exec_stall_q <= 1'b0;
            undef_trap_q <= 1'b0;
        end else begin
            exec_valid_q <= ex2_valid & !exec_stall_d & !pipe_flush & !pipe_cancel & !bounce_in;
            exec_stall_q <= exec_stall_d;
            undef_trap_q <= ex2_valid & !exec_stall_d & !pipe_flush & !pipe_cancel
                & bounce_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ls_len_q <= '0;
            ls_swap_q <= 1'b0;
            ls_dbl_q <= 1'b0;
            load_data_q <= '0;
        end else begin
            ls_len_q <= cp.ls_transfer_length1 | cp.ls_transfer_length2;
            ls_swap_q <= cp.ls_half_swap1 | cp.ls_half_swap2;
            ls_dbl_q <= cp.ls_doubleword1 | cp.ls_doubleword2;
            load_data_q <= cp.cp_to_core_data;
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, ex2_instr, cp.spare_busy_in_a, cp.spare_busy_in_b};
endmodule : cpif_core_end

// ==== design/cpif_consts.svh ====
// Constants for the coprocessor interface ends
`ifndef CPIF_CONSTS_SVH
`define CPIF_CONSTS_SVH
`define CPIF_DATA_W 64
`define CPIF_INSTR_W 26
`define CPIF_LEN_W 4
`define CPIF_ID_W 4
`define CPIF_NUM_LSB 8
`define CPIF_ID_MAX 15
`define CPIF_LAG_CYCLES 1
`endif

// ==== design/cpif_pkg.sv ====
// Types used by the coprocessor end of the coprocessor interface
package cpif_pkg;
    typedef enum logic [2:0] {
        CPIF_IDLE = 3'b001,
        CPIF_WAIT = 3'b010,
        CPIF_BUSY = 3'b100
    } cpif_cp_state_t;
endpackage : cpif_pkg

// ==== design/cpif_if.sv ====
// Interface joining the core end and the coprocessor end
`include "cpif_consts.svh"
interface cpif_if;
    // Core to coprocessors
    logic issue_stage_valid;
    logic [`CPIF_INSTR_W-1:0] issue_instr;
    logic decode_stage_valid;
    logic core_decode_stalled;
    logic core_execute_stalled;
    logic lsu_execute_hold;
    logic lsu_memory_hold;
    logic cancel_single;
    logic flush_from_execute;
    logic [`CPIF_DATA_W-1:0] core_to_cp_data;
    logic spare_abort_out;
    // Coprocessors to core, set 1 and set 2
    logic execute_busy_wait1;
    logic execute_busy_wait2;
    logic reject_to_undefined1;
    logic reject_to_undefined2;
    logic spare_busy_in_a;
    logic spare_busy_in_b;
    logic [`CPIF_LEN_W-1:0] ls_transfer_length1;
    logic [`CPIF_LEN_W-1:0] ls_transfer_length2;
    logic ls_half_swap1;
    logic ls_half_swap2;
    logic ls_doubleword1;
    logic ls_doubleword2;
    logic [`CPIF_DATA_W-1:0] cp_to_core_data;

    modport core (
        output issue_stage_valid, issue_instr, decode_stage_valid, core_decode_stalled,
        output core_execute_stalled, lsu_execute_hold, lsu_memory_hold, cancel_single,
        output flush_from_execute, core_to_cp_data, spare_abort_out,
        input execute_busy_wait1, execute_busy_wait2, reject_to_undefined1,
        input reject_to_undefined2, spare_busy_in_a, spare_busy_in_b,
        input ls_transfer_length1, ls_transfer_length2, ls_half_swap1, ls_half_swap2,
        input ls_doubleword1, ls_doubleword2, cp_to_core_data
    );
    modport cp (
        input issue_stage_valid, issue_instr, decode_stage_valid, core_decode_stalled,
        input core_execute_stalled, lsu_execute_hold, lsu_memory_hold, cancel_single,
        input flush_from_execute, core_to_cp_data, spare_abort_out,
        output execute_busy_wait1, reject_to_undefined1, ls_transfer_length1,
        output ls_half_swap1, ls_doubleword1, cp_to_core_data
    );
endinterface : cpif_if

// ==== design/cpif_stage.sv ====
// One registered pipeline stage with hold and kill
module cpif_stage #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Stage control
    input wire logic hold,
    input wire logic kill,
    // Data
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    output logic [W-1:0] out_data
);
    always_ff @(posedge core_clk) begin
        if (!rst_n || kill) begin
            out_valid <= 1'b0;
        end else if (!hold) begin
            out_valid <= in_valid;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_data <= '0;
        end else if (!hold) begin
            out_data <= in_data;
        end
    end
endmodule : cpif_stage

// ==== design/cpif_cp_end.sv ====
// Coprocessor end of the coprocessor interface
`include "cpif_consts.svh"
module cpif_cp_end #(
    parameter logic [`CPIF_ID_W-1:0] CP_ID = 4'h0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link
    cpif_if.cp core,
    // User side
    input wire logic user_decline,
    input wire logic [1:0] user_busy_cycles,
    input wire logic [`CPIF_DATA_W-1:0] user_store_data,
    output logic accept_q,
    output logic [`CPIF_INSTR_W-1:0] accept_instr_q,
    output logic [`CPIF_DATA_W-1:0] user_load_data_q
);
    // ==========================================================
    // Tracking one cycle behind the core
    logic f_valid;
    logic [`CPIF_INSTR_W-1:0] f_instr;
    logic mine;
    cpif_pkg::cpif_cp_state_t state_q;
    logic [1:0] busy_cnt_q;
    logic [`CPIF_INSTR_W-1:0] held_q;
    logic ex_valid_q;
    logic cm_valid_q;
    logic [`CPIF_INSTR_W-1:0] cm_instr_q;
    logic hold_prev_q;
    logic ex_hold;
    logic ex_load;
    logic kill;

    cpif_stage #(.W(`CPIF_INSTR_W)) u_fetch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold(core.core_decode_stalled),
        .kill(core.flush_from_execute),
        .in_valid(core.issue_stage_valid),
        .in_data(core.issue_instr),
        .out_valid(f_valid),
        .out_data(f_instr)
    );

    assign mine = f_valid & core.decode_stage_valid & !user_decline
        & (f_instr[`CPIF_NUM_LSB +: `CPIF_ID_W] == CP_ID);
    // Execute entry stays put while this end holds the core with busy
    assign ex_hold = ex_valid_q & core.execute_busy_wait1;
    assign ex_load = mine & !ex_hold;
    // Cancel reaches a held entry only while it is still in execute
    assign kill = core.flush_from_execute | (core.cancel_single & hold_prev_q);

    always_ff @(posedge core_clk) begin
        if (!rst_n || kill) begin
            state_q <= cpif_pkg::CPIF_IDLE;
            busy_cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                cpif_pkg::CPIF_IDLE: begin
                    if (ex_load && user_busy_cycles != 2'h0) begin
                        busy_cnt_q <= user_busy_cycles;
                        state_q <= cpif_pkg::CPIF_BUSY;
                    end
                end
                cpif_pkg::CPIF_BUSY: begin
                    busy_cnt_q <= busy_cnt_q - 2'h1;
                    if (busy_cnt_q == 2'h1) begin
                        state_q <= cpif_pkg::CPIF_IDLE;
                    end
                end
                default: state_q <= cpif_pkg::CPIF_IDLE;
            endcase
        end
    end

    // Instruction in core execute, then the cycle that shows its cancel
    always_ff @(posedge core_clk) begin
        if (!rst_n || kill) begin
            ex_valid_q <= 1'b0;
            held_q <= '0;
        end else if (!ex_hold) begin
            ex_valid_q <= mine;
            held_q <= f_instr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cm_valid_q <= 1'b0;
            cm_instr_q <= '0;
            hold_prev_q <= 1'b0;
        end else begin
            cm_valid_q <= ex_valid_q & !ex_hold & !kill;
            cm_instr_q <= held_q;
            hold_prev_q <= ex_hold;
        end
    end

    // ==========================================================
    // Registered replies; non-owner drives AND high and OR low
    always_ff @(posedge core_clk) begin
        if (!rst_n || kill) begin
            core.execute_busy_wait1 <= 1'b0;
            core.reject_to_undefined1 <= 1'b1;
        end else begin
            core.execute_busy_wait1 <= (state_q == cpif_pkg::CPIF_IDLE && ex_load
                && user_busy_cycles != 2'h0)
                || (state_q == cpif_pkg::CPIF_BUSY && busy_cnt_q != 2'h1);
            // Reject stays low for as long as the entry sits in execute
            core.reject_to_undefined1 <= !(ex_hold || ex_load);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core.ls_transfer_length1 <= '0;
            core.ls_half_swap1 <= 1'b0;
            core.ls_doubleword1 <= 1'b0;
            core.cp_to_core_data <= '0;
        end else begin
            core.ls_transfer_length1 <= mine ? f_instr[`CPIF_LEN_W-1:0] : '0;
            core.ls_half_swap1 <= mine & f_instr[`CPIF_LEN_W];
            core.ls_doubleword1 <= mine & f_instr[`CPIF_LEN_W+1];
            core.cp_to_core_data <= mine ? user_store_data : '0;
        end
    end

    // ==========================================================
    // User-side results, taken once cancel cannot apply
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            accept_q <= 1'b0;
            accept_instr_q <= '0;
            user_load_data_q <= '0;
        end else begin
            accept_q <= cm_valid_q && !core.cancel_single
                && !core.flush_from_execute;
            accept_instr_q <= cm_instr_q;
            user_load_data_q <= core.core_to_cp_data;
        end
    end
endmodule : cpif_cp_end

// ==== sim/cpif_sva.sv ====
// Protocol checker watching the wires between the two interface ends
module cpif_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Core to coprocessors
    input wire logic issue_stage_valid,
    input wire logic decode_stage_valid,
    input wire logic core_execute_stalled,
    input wire logic cancel_single,
    input wire logic flush_from_execute,
    input wire logic spare_abort_out,
    // Coprocessors to core
    input wire logic execute_busy_wait1,
    input wire logic execute_busy_wait2,
    input wire logic reject_to_undefined1
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Assertions
    spare_abort_a:
        assert property (spare_abort_out == 1'b0) else $error("spare abort driven");
    flush_busy_a:
        assert property (flush_from_execute |=> !execute_busy_wait1)
        else $error("busy after flush");
    flush_valid_a:
        assert property (flush_from_execute |=> !decode_stage_valid)
        else $error("decode valid after flush");
    decode_order_a:
        assert property ($rose(decode_stage_valid) |-> $past(issue_stage_valid))
        else $error("decode valid without issue");
    busy_cause_a:
        assert property ($rose(execute_busy_wait1) |-> $past(decode_stage_valid))
        else $error("busy without decoded instruction");
    accept_cause_a:
        assert property ($fell(reject_to_undefined1) |-> $past(decode_stage_valid))
        else $error("accept without decoded instruction");
    busy_bound_a:
        assert property (execute_busy_wait1 [*3] |=> !execute_busy_wait1)
        else $error("busy too long");
    busy_stall_a:
        assert property ((execute_busy_wait1 || execute_busy_wait2) && !flush_from_execute
            && !cancel_single |=> core_execute_stalled || flush_from_execute)
        else $error("busy did not stall execute");

    // ==========
    // Coverage
    cover property ($rose(execute_busy_wait1));
    cover property ($fell(reject_to_undefined1));
    cover property (flush_from_execute);
    cover property (cancel_single);
endmodule : cpif_sva

// ==== sim/coprocessor_interface_tb_top.sv ====
// Testbench joining the core end and the coprocessor end
`include "cpif_consts.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module coprocessor_interface_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] MY_ID = 4'h5;
    // ==========
    // Signals
    logic core_clk, rst_n, pipe_issue_valid, pipe_decode_stall, pipe_lsu_exec_hold;
    logic pipe_lsu_mem_hold, pipe_cancel, pipe_flush, user_decline, accept_q;
    logic [`CPIF_INSTR_W-1:0] pipe_issue_instr, accept_instr_q, acc_seen;
    logic [`CPIF_DATA_W-1:0] pipe_store_data, user_store_data, load_data_q, user_load_data_q;
    logic [`CPIF_DATA_W-1:0] ld_seen;
    logic [1:0] user_busy_cycles;
    logic exec_valid_q, exec_stall_q, undef_trap_q, ls_swap_q, ls_dbl_q;
    logic [3:0] ls_len_q, s2_len;
    logic s2_reject, s2_swap, s2_dbl;
    logic [5:0] ls_seen [2];
    int bad_count, tests_run, n_acc, n_ex, n_trap, n_stall, n_busy;
    // ==========
    // Design and checker
    cpif_if u_cpif_if ();
    assign u_cpif_if.execute_busy_wait2 = 1'b0;
    assign u_cpif_if.spare_busy_in_a = 1'b0;
    assign u_cpif_if.spare_busy_in_b = 1'b0;
    assign u_cpif_if.reject_to_undefined2 = s2_reject;
    assign u_cpif_if.ls_transfer_length2 = s2_len;
    assign u_cpif_if.ls_half_swap2 = s2_swap;
    assign u_cpif_if.ls_doubleword2 = s2_dbl;
    cpif_core_end u_cpif_core_end (.core_clk(core_clk), .rst_n(rst_n), .cp(u_cpif_if.core),
        .pipe_issue_valid(pipe_issue_valid), .pipe_issue_instr(pipe_issue_instr),
        .pipe_decode_stall(pipe_decode_stall), .pipe_lsu_exec_hold(pipe_lsu_exec_hold),
        .pipe_lsu_mem_hold(pipe_lsu_mem_hold), .pipe_cancel(pipe_cancel),
        .pipe_flush(pipe_flush), .pipe_store_data(pipe_store_data),
        .exec_valid_q(exec_valid_q), .exec_stall_q(exec_stall_q), .undef_trap_q(undef_trap_q),
        .ls_len_q(ls_len_q), .ls_swap_q(ls_swap_q), .ls_dbl_q(ls_dbl_q),
        .load_data_q(load_data_q));
    cpif_cp_end #(.CP_ID(MY_ID)) u_cpif_cp_end (.core_clk(core_clk), .rst_n(rst_n),
        .core(u_cpif_if.cp), .user_decline(user_decline), .user_busy_cycles(user_busy_cycles),
        .user_store_data(user_store_data), .accept_q(accept_q),
        .accept_instr_q(accept_instr_q), .user_load_data_q(user_load_data_q));
    cpif_sva u_cpif_sva (.core_clk(core_clk), .rst_n(rst_n),
        .issue_stage_valid(u_cpif_if.issue_stage_valid),
        .decode_stage_valid(u_cpif_if.decode_stage_valid),
        .core_execute_stalled(u_cpif_if.core_execute_stalled),
        .cancel_single(u_cpif_if.cancel_single),
        .flush_from_execute(u_cpif_if.flush_from_execute),
        .spare_abort_out(u_cpif_if.spare_abort_out),
        .execute_busy_wait1(u_cpif_if.execute_busy_wait1),
        .execute_busy_wait2(u_cpif_if.execute_busy_wait2),
        .reject_to_undefined1(u_cpif_if.reject_to_undefined1));
    // ==========
    // Helpers
    function automatic logic [`CPIF_INSTR_W-1:0] mk(input logic [3:0] num, input logic [5:0] c);
        mk = {14'h0000, num, 2'b00, c};
    endfunction : mk
    task automatic issue(input logic [`CPIF_INSTR_W-1:0] ins, input logic dec,
        input logic [1:0] bsy);
        @(posedge core_clk);
        pipe_issue_valid <= 1'b1;
        pipe_issue_instr <= ins;
        user_decline <= dec;
        user_busy_cycles <= bsy;
        @(posedge core_clk);
        pipe_issue_valid <= 1'b0;
    endtask : issue
    task automatic observe(input int cyc);
        n_acc = 0;
        n_ex = 0;
        n_trap = 0;
        n_stall = 0;
        n_busy = 0;
        repeat (cyc) begin
            @(negedge core_clk);
            if (accept_q === 1'b1) begin
                n_acc++;
                acc_seen = accept_instr_q;
            end
            if (exec_valid_q === 1'b1) begin
                ls_seen[n_ex % 2] = {ls_dbl_q, ls_swap_q, ls_len_q};
                ld_seen = load_data_q;
                n_ex++;
            end
            n_trap += int'(undef_trap_q === 1'b1);
            n_stall += int'(u_cpif_if.core_execute_stalled === 1'b1);
            n_busy += int'(u_cpif_if.execute_busy_wait1 === 1'b1);
        end
    endtask : observe
    // ==========
    // Scenarios
    task automatic t_accept;
        @(posedge core_clk);
        pipe_issue_valid <= 1'b1;
        pipe_issue_instr <= mk(MY_ID, 6'h1A);
        @(posedge core_clk);
        pipe_issue_instr <= mk(MY_ID, 6'h23);
        @(posedge core_clk);
        pipe_issue_valid <= 1'b0;
        observe(24);
        `CHK("accepts", 2, n_acc)
        `CHK("completions", 2, n_ex)
        `CHK("traps", 0, n_trap)
        `CHK("accepted word", mk(MY_ID, 6'h23), acc_seen)
        `CHK("first ls ctl", 6'h1A, ls_seen[0])
        `CHK("second ls ctl", 6'h23, ls_seen[1])
        `CHK("data to core", user_store_data, ld_seen)
        `CHK("data to cp", pipe_store_data, user_load_data_q)
        $display("test accept done");
    endtask : t_accept
    task automatic t_bounce;
        for (int k = 0; k < 2; k++) begin
            issue(mk(k == 0 ? MY_ID : 4'h6, 6'h00), k == 0, 2'h0);
            observe(20);
            `CHK("bounce traps", 1, n_trap)
            `CHK("bounce accepts", 0, n_acc)
        end
        $display("test bounce done");
    endtask : t_bounce
    task automatic t_set2;
        @(posedge core_clk);
        s2_reject <= 1'b0;
        s2_len <= 4'h7;
        s2_swap <= 1'b1;
        s2_dbl <= 1'b1;
        issue(mk(4'h9, 6'h00), 1'b0, 2'h0);
        observe(20);
        `CHK("set2 traps", 0, n_trap)
        `CHK("set2 completions", 1, n_ex)
        `CHK("set2 ls ctl", 6'h37, ls_seen[0])
        @(posedge core_clk);
        s2_reject <= 1'b1;
        s2_len <= 4'h0;
        s2_swap <= 1'b0;
        s2_dbl <= 1'b0;
        $display("test set2 done");
    endtask : t_set2
    task automatic t_busy;
        issue(mk(MY_ID, 6'h00), 1'b0, 2'h2);
        observe(20);
        `CHK("busy cycles", 2, n_busy)
        `CHK("execute stall cycles", 2, n_stall)
        `CHK("busy completions", 1, n_ex)
        $display("test busy done");
    endtask : t_busy
    task automatic t_kill(input logic fl);
        issue(mk(MY_ID, 6'h00), 1'b0, 2'h3);
        for (int k = 0; k < 10; k++) begin
            @(negedge core_clk);
            if (u_cpif_if.execute_busy_wait1 === 1'b1) break;
        end
        @(posedge core_clk);
        pipe_flush <= fl;
        pipe_cancel <= !fl;
        @(posedge core_clk);
        pipe_flush <= 1'b0;
        pipe_cancel <= 1'b0;
        observe(20);
        `CHK("killed completions", 0, n_ex)
        `CHK("killed traps", 0, n_trap)
        $display("test kill done");
    endtask : t_kill
    task automatic t_holds;
        int n;
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            {pipe_decode_stall, pipe_lsu_exec_hold, pipe_lsu_mem_hold} <= 3'h4 >> k;
            @(posedge core_clk);
            {pipe_decode_stall, pipe_lsu_exec_hold, pipe_lsu_mem_hold} <= 3'h0;
            n = 0;
            repeat (6) begin
                @(negedge core_clk);
                n += int'({u_cpif_if.core_decode_stalled, u_cpif_if.lsu_execute_hold,
                    u_cpif_if.lsu_memory_hold} === (3'h4 >> k));
            end
            `CHK("hold report cycles", 1, n)
        end
        $display("test holds done");
    endtask : t_holds
    task automatic end_of_test;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ==========
    // Sequence
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        end_of_test;
    end
    initial begin
        {rst_n, pipe_issue_valid, pipe_decode_stall, pipe_lsu_exec_hold} = 4'h0;
        {pipe_lsu_mem_hold, pipe_cancel, pipe_flush, user_decline} = 4'h0;
        {s2_reject, s2_swap, s2_dbl, s2_len} = 7'h40;
        pipe_issue_instr = '0;
        user_busy_cycles = 2'h0;
        pipe_store_data = 64'h0123_4567_89AB_CDEF;
        user_store_data = 64'hA5A5_0F0F_1234_5678;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK("reset reject", 1'b1, u_cpif_if.reject_to_undefined1)
        `CHK("reset busy", 1'b0, u_cpif_if.execute_busy_wait1)
        `CHK("reset issue valid", 1'b0, u_cpif_if.issue_stage_valid)
        t_accept;
        t_bounce;
        t_set2;
        t_busy;
        t_kill(1'b1);
        t_kill(1'b0);
        t_holds;
        end_of_test;
    end
endmodule : coprocessor_interface_tb_top
